/* File: inc/pmrc_params.svh */
`ifndef PMRC_PARAMS_SVH
`define PMRC_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PMRC_IDX_PMODE 8'h87
`define PMRC_IDX_RESET_SOURCE_REGISTER 8'h88
`define PMRC_IDX_MONCTL 8'h89

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMRC_PM_IDLE 0
`define PMRC_PM_STOP 1
`define PMRC_PM_GF_LO 2
`define PMRC_PM_GF_HI 7
`define PMRC_RS_PORF 1
`define PMRC_MC_LEVEL 5
`define PMRC_MC_STAT 6
`define PMRC_MC_EN 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMRC_RST_GF 6'h00
`define PMRC_RST_MON_EN 1'b1
`define PMRC_RST_MON_SEL 1'b1
`define PMRC_RST_MON_HIGH 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMRC_CLK_NS 100
`define PMRC_POR_DLY_NS 2000
`define PMRC_CAL_NS 800
`define PMRC_POR_DLY_CYC \
    ((`PMRC_POR_DLY_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)
`define PMRC_CAL_CYC \
    ((`PMRC_CAL_NS + `PMRC_CLK_NS - 1) / `PMRC_CLK_NS)
`define PMRC_WDT_DIV 12

`endif

/* File: inc/pmrc_pkg.sv */
package pmrc_pkg;

    // ----------------------------------------------------------------
    // Reset and power sequencing states
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_HOLD = 7'b000_0001,
        ST_DELAY = 7'b000_0010,
        ST_CAL = 7'b000_0100,
        ST_LOCK = 7'b000_1000,
        ST_RUN = 7'b001_0000,
        ST_IDLE = 7'b010_0000,
        ST_STOP = 7'b100_0000
    } pmrc_state_type;

endpackage

/* File: rtl/pmrc_req_sync.sv */
`timescale 1ns/1ps

module pmrc_req_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Raw requests: bit 1 supply monitor, bit 0 other sources
    input wire logic [1:0] reqRaw,
    // Requests aligned to the system clock
    output logic [1:0] reqSync
);

    logic [1:0] meta_q;
    logic [1:0] sync_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end else begin
            meta_q <= reqRaw;
            sync_q <= meta_q;
        end
    end

    assign reqSync = sync_q;

endmodule // pmrc_req_sync

/* File: rtl/pmrc_power_reset.sv */
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_power_reset
    import pmrc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Supply monitor and regulator
    input wire logic supplyAbove,
    input wire logic regBelowHigh,
    // Core events
    input wire logic irqPending,
    input wire logic swResetReq,
    input wire logic flashOpReq,
    // Open-drain reset pin
    input wire logic rstPinIn,
    output logic rstPinOut,
    output logic rstPinOe,
    // Core control
    output logic coreReset,
    output logic cpuClockEn,
    output logic oscEnable,
    output logic fetchStart,
    output logic calibrate,
    output logic wdtEnable,
    output logic wdtTick,
    output logic portForceOnes,
    output logic weakPullUp,
    output logic monitorEnable,
    output logic monitorHigh
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pmrc_state_type state_q;
    logic [7:0] cnt_q;
    logic [3:0] wdtDiv_q;
    logic [5:0] gf_q;
    logic porCause_q;
    logic monCause_q;
    logic porFlag_q;
    logic monEn_q;
    logic monSel_q;
    logic monHigh_q;
    logic waitReq_q;
    logic [31:0] readData_q;
    logic coreRst_q;
    logic cpuClkEn_q;
    logic oscEn_q;
    logic fetch_q;
    logic calib_q;
    logic wdtEn_q;
    logic wdtTick_q;
    logic portForce_q;
    logic weakPull_q;
    logic rstPinOe_q;
    logic rstPinOut_q;
    logic busReq;
    logic busTake;
    logic wrPmode;
    logic wrRstsrc;
    logic wrMonctl;
    logic inReset;
    logic monReq;
    logic pinReq;
    logic flashErr;
    logic [1:0] reqSync;
    logic rstNow;
    logic holdNow;
    logic calDone;
    logic [31:0] readMux;

    function automatic logic hitReg(input logic [9:0] a,
                                    input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    // supply low request
    assign monReq = monEn_q & monSel_q & !supplyAbove;
    assign flashErr = flashOpReq & !(monEn_q & monHigh_q);
    // Own pin drive is masked, or every driven reset would re-trigger
    // itself; a pin that rises slowly after release still would
    assign pinReq = !rstPinIn & !rstPinOe_q;

    pmrc_req_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .reqRaw({monReq, swResetReq | flashErr | pinReq}),
        .reqSync(reqSync)
    );

    assign rstNow = reqSync[1] | reqSync[0];
    // power-up waits on the supply itself
    assign holdNow = porCause_q ? !supplyAbove
                                : (monCause_q & reqSync[1]);
    assign inReset = !(state_q inside {ST_RUN, ST_IDLE, ST_STOP});
    assign calDone = (state_q == ST_CAL)
        && (cnt_q == 8'(`PMRC_CAL_CYC - 1));

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    assign busReq = read | write;
    assign busTake = busReq & !waitReq_q;
    assign wrPmode = busTake & write & hitReg(address, `PMRC_IDX_PMODE);
    assign wrRstsrc = busTake & write
        & hitReg(address, `PMRC_IDX_RESET_SOURCE_REGISTER);
    assign wrMonctl = busTake & write
        & hitReg(address, `PMRC_IDX_MONCTL);

    // One wait cycle: data is prepared, then the access is taken
    always_ff @(posedge clock) begin
        if (!nrst) begin
            waitReq_q <= 1'b1;
        end else begin
            waitReq_q <= !(busReq & waitReq_q);
        end
    end

    always_comb begin
        readMux = 32'h0000_0000;
        if (hitReg(address, `PMRC_IDX_PMODE)) begin
            readMux[`PMRC_PM_GF_HI:`PMRC_PM_GF_LO] = gf_q;
        end else if (hitReg(address, `PMRC_IDX_RESET_SOURCE_REGISTER)) begin
            readMux[`PMRC_RS_PORF] = porFlag_q;
        end else if (hitReg(address, `PMRC_IDX_MONCTL)) begin
            readMux[`PMRC_MC_EN] = monEn_q;
            readMux[`PMRC_MC_STAT] = supplyAbove;
            readMux[`PMRC_MC_LEVEL] = monHigh_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            readData_q <= 32'h0000_0000;
        end else if (busReq & waitReq_q) begin
            readData_q <= readMux;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // general flags, cleared by any reset
    always_ff @(posedge clock) begin
        if (!nrst || inReset) begin
            gf_q <= `PMRC_RST_GF;
        end else if (wrPmode) begin
            gf_q <= writedata[`PMRC_PM_GF_HI:`PMRC_PM_GF_LO];
        end
    end

    // monitor state survives all but power-on
    always_ff @(posedge clock) begin
        if (!nrst) begin
            monEn_q <= `PMRC_RST_MON_EN;
            monHigh_q <= `PMRC_RST_MON_HIGH;
        end else if (wrMonctl) begin
            monEn_q <= writedata[`PMRC_MC_EN];
            monHigh_q <= writedata[`PMRC_MC_LEVEL];
        end
    end

    // firmware selects monitor as source here
    always_ff @(posedge clock) begin
        if (!nrst) begin
            monSel_q <= `PMRC_RST_MON_SEL;
        end else if (wrRstsrc) begin
            monSel_q <= writedata[`PMRC_RS_PORF];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            porFlag_q <= 1'b0;
        end else if (calDone) begin
            porFlag_q <= porCause_q;
        end else if (state_q == ST_HOLD && !porCause_q) begin
            porFlag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q <= ST_HOLD;
            porCause_q <= 1'b1;
            monCause_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    cnt_q <= 8'h00;
                    if (!holdNow) begin
                        if (!porCause_q && monHigh_q && regBelowHigh) begin
                            state_q <= ST_LOCK;
                        end else if (porCause_q) begin
                            state_q <= ST_DELAY;
                        end else begin
                            state_q <= ST_CAL;
                        end
                    end
                end
                ST_DELAY: begin
                    if (cnt_q == 8'(`PMRC_POR_DLY_CYC - 1)) begin
                        cnt_q <= 8'h00;
                        state_q <= ST_CAL;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ST_CAL: begin
                    if (calDone) begin
                        state_q <= ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ST_LOCK: begin
                    // Only a power-on reset leaves this state
                    state_q <= ST_LOCK;
                end
                ST_RUN, ST_IDLE, ST_STOP: begin
                    if (rstNow) begin
                        state_q <= ST_HOLD;
                        porCause_q <= 1'b0;
                        monCause_q <= reqSync[1];
                    end else if (state_q == ST_IDLE && irqPending) begin
                        state_q <= ST_RUN;
                    end else if (state_q == ST_RUN && wrPmode
                                 && writedata[`PMRC_PM_STOP]) begin
                        state_q <= ST_STOP;
                    end else if (state_q == ST_RUN && wrPmode
                                 && writedata[`PMRC_PM_IDLE]) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Core control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            coreRst_q <= 1'b1;
            cpuClkEn_q <= 1'b0;
            oscEn_q <= 1'b1;
            calib_q <= 1'b0;
            portForce_q <= 1'b1;
            weakPull_q <= 1'b1;
        end else begin
            // core, registers, stack pointer, irq, timers
            coreRst_q <= inReset;
            cpuClkEn_q <= state_q == ST_RUN;
            oscEn_q <= state_q != ST_STOP;
            calib_q <= state_q == ST_CAL;
            // ports to all ones, pull-ups kept on
            portForce_q <= inReset;
            weakPull_q <= 1'b1;
        end
    end

    // pin driven for power-on and monitor resets
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rstPinOe_q <= 1'b1;
            rstPinOut_q <= 1'b0;
        end else begin
            rstPinOe_q <= inReset & (porCause_q | monCause_q);
            rstPinOut_q <= 1'b0;
        end
    end

    // restart at address zero on internal clock
    always_ff @(posedge clock) begin
        if (!nrst) begin
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= calDone;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || inReset) begin
            wdtEn_q <= 1'b0;
            wdtDiv_q <= 4'h0;
            wdtTick_q <= 1'b0;
        end else begin
            wdtEn_q <= 1'b1;
            wdtTick_q <= 1'b0;
            if (state_q != ST_STOP) begin
                if (wdtDiv_q == 4'(`PMRC_WDT_DIV - 1)) begin
                    wdtDiv_q <= 4'h0;
                    wdtTick_q <= 1'b1;
                end else begin
                    wdtDiv_q <= wdtDiv_q + 4'h1;
                end
            end
        end
    end

    assign readdata = readData_q;
    assign waitrequest = waitReq_q;
    assign rstPinOut = rstPinOut_q;
    assign rstPinOe = rstPinOe_q;
    assign coreReset = coreRst_q;
    assign cpuClockEn = cpuClkEn_q;
    assign oscEnable = oscEn_q;
    assign fetchStart = fetch_q;
    assign calibrate = calib_q;
    assign wdtEnable = wdtEn_q;
    assign wdtTick = wdtTick_q;
    assign portForceOnes = portForce_q;
    assign weakPullUp = weakPull_q;
    assign monitorEnable = monEn_q;
    assign monitorHigh = monHigh_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence sq_stop_write;
        state_q == ST_RUN && !rstNow && wrPmode
            && writedata[`PMRC_PM_STOP];
    endsequence

    sequence sq_idle_write;
        state_q == ST_RUN && !rstNow && wrPmode
            && !writedata[`PMRC_PM_STOP] && writedata[`PMRC_PM_IDLE];
    endsequence

    sequence sq_mode_read;
        read && waitReq_q && hitReg(address, `PMRC_IDX_PMODE);
    endsequence

    a_stop_halts_osc:
        assert property (sq_stop_write |=> state_q == ST_STOP
            ##1 (!oscEn_q && !cpuClkEn_q))
        else $error("stop write did not halt oscillator");

    a_idle_gates_cpu:
        assert property (sq_idle_write |=> ##1 (!cpuClkEn_q && oscEn_q))
        else $error("idle write did not gate only the cpu");

    a_mode_bits_zero:
        assert property (sq_mode_read |=> readData_q[1:0] == 2'b00
            && readData_q[7:2] == gf_q)
        else $error("mode register read back wrong");

    a_por_flag_set:
        assert property (calDone && porCause_q |=> porFlag_q && fetch_q)
        else $error("power-on flag not set at exit");

    a_mon_no_delay:
        assert property (state_q == ST_HOLD && !holdNow && !porCause_q
            && !(monHigh_q && regBelowHigh) |=> state_q == ST_CAL)
        else $error("monitor reset took the power-on delay");

    a_idle_irq_wake:
        assert property (state_q == ST_IDLE && irqPending && !rstNow
            |=> state_q == ST_RUN ##1 cpuClkEn_q)
        else $error("interrupt did not end idle");

    a_req_reaches_hold:
        assert property (state_q == ST_RUN && reqSync != 2'b00
            |=> state_q == ST_HOLD ##1 (coreRst_q && portForce_q))
        else $error("reset request not taken");

    a_pin_driven_low:
        assert property (state_q == ST_HOLD && porCause_q
            |=> rstPinOe_q && !rstPinOut_q)
        else $error("reset pin not driven during power-on");

    a_wdt_tick_space:
        assert property (wdtTick_q && state_q == ST_RUN && !rstNow
            |=> !wdtTick_q [*8])
        else $error("watchdog tick spacing too short");

endmodule // pmrc_power_reset

/* File: testbench/pmrc_partner.sv */
`timescale 1ns/1ps

module pmrc_partner (
    // Test controls
    input wire logic supplyOk,
    input wire logic extRstN,
    input wire logic regLow,
    // Reset pin drive from the device
    input wire logic rstPinOut,
    input wire logic rstPinOe,
    // Monitor, regulator and pin level seen by the device
    output logic supplyAbove,
    output logic regBelowHigh,
    output logic rstPinIn
);
    assign supplyAbove = supplyOk;
    assign regBelowHigh = regLow;
    // Pull-up on the pin: a released pin reads high, never the last drive
    assign rstPinIn = extRstN & (rstPinOe ? rstPinOut : 1'h1);
endmodule // pmrc_partner

/* File: testbench/pmrc_power_reset_tb_top.sv */
`timescale 1ns/1ps
`include "pmrc_params.svh"

module pmrc_power_reset_tb_top;
    logic clock = 0;
    logic nrst = 0;
    logic [9:0] address = '0;
    logic read = 0;
    logic write = 0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest, supplyAbove, regBelowHigh, rstPinIn, rstPinOut;
    logic rstPinOe, coreReset, cpuClockEn, oscEnable, fetchStart, calibrate;
    logic wdtEnable, wdtTick, portForceOnes, weakPullUp, monitorEnable;
    logic monitorHigh;
    logic supplyOk = 0, extRstN = 1, regLow = 0, irqPending = 0;
    logic swResetReq = 0, flashOpReq = 0;
    logic [31:0] rd;
    int n_fail = 0, checks = 0, waited, n;
    int flags, por, monEn, monHigh;

    always #50 clock = ~clock;

    pmrc_power_reset i_pmrc_power_reset (.clock, .nrst, .address, .read,
        .write, .writedata, .readdata, .waitrequest, .supplyAbove,
        .regBelowHigh, .irqPending, .swResetReq, .flashOpReq, .rstPinIn,
        .rstPinOut, .rstPinOe, .coreReset, .cpuClockEn, .oscEnable,
        .fetchStart, .calibrate, .wdtEnable, .wdtTick, .portForceOnes,
        .weakPullUp, .monitorEnable, .monitorHigh);

    pmrc_partner i_pmrc_partner (.supplyOk, .extRstN, .regLow, .rstPinOut,
        .rstPinOe, .supplyAbove, .regBelowHigh, .rstPinIn);

    // ----------------------------------------------------------------
    // Model and helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] expRead(input logic [7:0] idx);
        case (idx)
            `PMRC_IDX_PMODE: return 32'(flags << 2);
            `PMRC_IDX_RESET_SOURCE_REGISTER: return 32'(por << 1);
            `PMRC_IDX_MONCTL: return 32'((monEn << 7) | (monHigh << 5)
                | (int'(supplyOk) << 6));
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d);
        int k;
        @(posedge clock);
        address <= {idx, 2'h0};
        writedata <= {24'h00_0000, d};
        read <= !wr;
        write <= wr;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'h0 && k < 50);
        if (k >= 50) n_fail++;
        rd = readdata;
        read <= 0;
        write <= 0;
        if (wr && idx == `PMRC_IDX_PMODE) flags = d[7:2];
        if (wr && idx == `PMRC_IDX_MONCTL) begin
            monEn = d[7];
            monHigh = d[5];
        end
    endtask

    task automatic rdChk(input logic [7:0] idx);
        bus(0, idx, 8'h00);
        check(rd, expRead(idx));
    endtask

    task automatic waitSig(input int which, input logic lvl, input int lim);
        logic s;
        waited = 0;
        do begin
            @(posedge clock);
            waited++;
            case (which)
                0: s = coreReset;
                1: s = calibrate;
                2: s = fetchStart;
                3: s = cpuClockEn;
                4: s = wdtTick;
                default: s = oscEnable;
            endcase
        end while (s !== lvl && waited < lim);
        check(32'(s), 32'(lvl));
    endtask

    task automatic pulseSw();
        @(posedge clock);
        swResetReq <= 1;
        @(posedge clock);
        swResetReq <= 0;
    endtask

    task automatic porSeq(input int cyc);
        nrst <= 0;
        repeat (cyc) @(posedge clock);
        nrst <= 1;
        flags = 0;
        por = 1;
        monEn = 1;
        monHigh = 0;
    endtask

    task automatic final_report();
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(81608));
        repeat (7) @(posedge clock);
        check(32'(coreReset), 32'h1);
        check(32'(rstPinOe & ~rstPinOut), 32'h1);
        check(32'(portForceOnes & weakPullUp), 32'h1);
        check(32'(monitorEnable & ~monitorHigh), 32'h1);
        // Seven edges already spent in reset, one more makes eight
        porSeq(1);
        repeat (10) @(posedge clock);
        check(32'(coreReset & rstPinOe), 32'h1);
        supplyOk <= 1;
        waitSig(1, 1, 100);
        check(32'(waited >= `PMRC_POR_DLY_CYC), 32'h1);
        // Fetch pulse comes on run entry, before calibrate output falls
        waitSig(2, 1, 50);
        n = waited;
        waitSig(1, 0, 5);
        check(n + waited, `PMRC_CAL_CYC);
        check(32'(wdtEnable & weakPullUp), 32'h1);
        waitSig(4, 1, 30);
        waitSig(4, 0, 3);
        n = waited;
        waitSig(4, 1, 30);
        check(n + waited, `PMRC_WDT_DIV);
        rdChk(`PMRC_IDX_RESET_SOURCE_REGISTER);
        rdChk(`PMRC_IDX_MONCTL);
        rdChk(8'h90);
        for (int i = 0; i < 6; i++) begin
            bus(1, `PMRC_IDX_PMODE, 8'($urandom) & 8'hFC);
            rdChk(`PMRC_IDX_PMODE);
        end
        bus(1, `PMRC_IDX_PMODE, {6'(flags), 2'h1});
        waitSig(3, 0, 10);
        check(32'(oscEnable), 32'h1);
        irqPending <= 1;
        waitSig(3, 1, 10);
        irqPending <= 0;
        rdChk(`PMRC_IDX_PMODE);
        // Firmware turns the monitor off; a soft reset must not revive it
        bus(1, `PMRC_IDX_MONCTL, 8'h00);
        bus(1, `PMRC_IDX_PMODE, {6'(flags), 2'h2});
        waitSig(5, 0, 10);
        check(32'(cpuClockEn), 32'h0);
        irqPending <= 1;
        repeat (5) @(posedge clock);
        irqPending <= 0;
        check(32'(oscEnable), 32'h0);
        pulseSw();
        waitSig(0, 1, 10);
        check(32'(rstPinOe), 32'h0);
        flags = 0;
        por = 0;
        waitSig(1, 1, 20);
        waitSig(2, 1, 20);
        n = waited;
        waitSig(1, 0, 5);
        check(n + waited, `PMRC_CAL_CYC);
        rdChk(`PMRC_IDX_MONCTL);
        rdChk(`PMRC_IDX_RESET_SOURCE_REGISTER);
        rdChk(`PMRC_IDX_PMODE);
        flashOpReq <= 1;
        @(posedge clock);
        flashOpReq <= 0;
        waitSig(0, 1, 10);
        waitSig(2, 1, 50);
        // Enable first, then select; high threshold only around the write
        bus(1, `PMRC_IDX_MONCTL, 8'h80);
        bus(1, `PMRC_IDX_RESET_SOURCE_REGISTER, 8'h02);
        bus(1, `PMRC_IDX_MONCTL, 8'hA0);
        flashOpReq <= 1;
        @(posedge clock);
        flashOpReq <= 0;
        repeat (10) @(posedge clock);
        check(32'(coreReset), 32'h0);
        bus(1, `PMRC_IDX_MONCTL, 8'h80);
        supplyOk <= 0;
        waitSig(0, 1, 10);
        repeat (30) @(posedge clock);
        check(32'(coreReset & rstPinOe), 32'h1);
        supplyOk <= 1;
        waitSig(1, 1, 20);
        check(32'(waited < `PMRC_POR_DLY_CYC), 32'h1);
        waitSig(2, 1, 30);
        rdChk(`PMRC_IDX_RESET_SOURCE_REGISTER);
        extRstN <= 0;
        waitSig(0, 1, 10);
        extRstN <= 1;
        waitSig(2, 1, 50);
        bus(1, `PMRC_IDX_MONCTL, 8'hA0);
        regLow <= 1;
        pulseSw();
        waitSig(0, 1, 10);
        repeat (100) @(posedge clock);
        check(32'(coreReset), 32'h1);
        porSeq(8);
        waitSig(2, 1, 100);
        check(32'(monitorHigh), 32'h0);
        rdChk(`PMRC_IDX_MONCTL);
        regLow <= 0;
        final_report();
    end

    initial begin
        #(`PMRC_CLK_NS * 20000);
        n_fail++;
        final_report();
    end
endmodule // pmrc_power_reset_tb_top
